/* File: logic/bmb_bridge_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module bmb_bridge_ctrl #(
	parameter int STANDBY_CYC = bmb_pkg::STANDBY_CYC,
	parameter int OFF_CYC = bmb_pkg::OFF_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic dir_in_a,
	input wire logic dir_in_b,
	input wire logic sense_trip,
	input wire logic zero_current,
	output var bmb_pkg::bmb_gates_type gates,
	output logic standby
);

	localparam int SBW = $clog2(STANDBY_CYC + 1);
	localparam int OFW = $clog2(OFF_CYC + 1);
	localparam int HALF_CYC = OFF_CYC / 2;
	localparam int BLW = $clog2(bmb_pkg::BLANK_CYC + 1);
	localparam int FLW = $clog2(bmb_pkg::FILT_CYC + 1);
	localparam int WKW = $clog2(bmb_pkg::WAKE_CYC + 1);
	localparam int DTW = $clog2(bmb_pkg::DEAD_CYC + 1);

	bmb_pkg::bmb_state_type state_q;
	bmb_pkg::bmb_state_type state_d;
	bmb_pkg::bmb_state_type run_st;
	bmb_pkg::bmb_gates_type gate_q;
	bmb_pkg::bmb_gates_type want;
	logic [1:0] in_now;
	logic [1:0] in_q;
	logic in_chg;
	logic dir_q;
	logic trip_ok;
	logic [SBW-1:0] sb_q;
	logic [OFW-1:0] off_q;
	logic [BLW-1:0] blank_q;
	logic [FLW-1:0] filt_q;
	logic [WKW-1:0] wake_q;
	logic [DTW-1:0] dead_q;

	assign in_now = {dir_in_a, dir_in_b};
	assign in_chg = in_now != in_q;
	assign gates = gate_q;
	assign standby = state_q == bmb_pkg::ST_STANDBY;
	assign trip_ok = state_q == bmb_pkg::ST_CHARGE && blank_q == '0
		&& filt_q == FLW'(bmb_pkg::FILT_CYC); // R05 R14

	////////////////////////////////////////////////////////////////
	// input tracking

	always_ff @(posedge clk) begin
		if (reset) begin
			in_q <= bmb_pkg::IN_STOP;
		end else begin
			in_q <= in_now;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dir_q <= 1'b0;
		end else if (in_now == bmb_pkg::IN_FWD) begin
			dir_q <= 1'b0; // R14
		end else if (in_now == bmb_pkg::IN_REV) begin
			dir_q <= 1'b1; // R14
		end
	end

	////////////////////////////////////////////////////////////////
	// mode sequencing

	always_comb begin
		case (in_now)
			bmb_pkg::IN_STOP: run_st = bmb_pkg::ST_OFF; // R02
			bmb_pkg::IN_BRAKE: run_st = bmb_pkg::ST_BRAKE; // R01
			default: run_st = bmb_pkg::ST_CHARGE; // R01
		endcase
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			bmb_pkg::ST_STANDBY: begin
				if (in_now != bmb_pkg::IN_STOP) begin
					state_d = bmb_pkg::ST_WAKE; // R03
				end
			end
			bmb_pkg::ST_WAKE: begin
				if (wake_q == '0) begin
					state_d = run_st; // R04
				end
			end
			bmb_pkg::ST_OFF: begin
				if (sb_q == SBW'(STANDBY_CYC - 1)) begin
					state_d = bmb_pkg::ST_STANDBY; // R02
				end
			end
			bmb_pkg::ST_BRAKE: begin
				state_d = bmb_pkg::ST_BRAKE;
			end
			bmb_pkg::ST_CHARGE: begin
				if (trip_ok) begin
					state_d = bmb_pkg::ST_FAST; // R14
				end
			end
			bmb_pkg::ST_FAST: begin
				if (zero_current) begin
					state_d = bmb_pkg::ST_ZERO; // R11
				end else if (off_q == OFW'(HALF_CYC)) begin
					state_d = bmb_pkg::ST_SLOW; // R10
				end
			end
			bmb_pkg::ST_SLOW: begin
				if (off_q == '0) begin
					state_d = bmb_pkg::ST_CHARGE; // R14
				end else if (zero_current) begin
					state_d = bmb_pkg::ST_ZERO; // R11
				end
			end
			bmb_pkg::ST_ZERO: begin
				if (off_q == '0) begin
					state_d = bmb_pkg::ST_CHARGE; // R14
				end
			end
			default: state_d = bmb_pkg::ST_OFF;
		endcase
		if (in_chg && state_q != bmb_pkg::ST_STANDBY && state_q != bmb_pkg::ST_WAKE) begin
			state_d = run_st; // R08
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= bmb_pkg::ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// timers

	always_ff @(posedge clk) begin
		if (reset) begin
			sb_q <= '0;
		end else if (state_q != bmb_pkg::ST_OFF || in_now != bmb_pkg::IN_STOP) begin
			sb_q <= '0; // R15
		end else if (sb_q != SBW'(STANDBY_CYC - 1)) begin
			sb_q <= sb_q + SBW'(1); // R02
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wake_q <= '0;
		end else if (state_q == bmb_pkg::ST_STANDBY) begin
			wake_q <= WKW'(bmb_pkg::WAKE_CYC - bmb_pkg::WAKE_LAT); // R04
		end else if (wake_q != '0) begin
			wake_q <= wake_q - WKW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			off_q <= '0;
		end else if (state_q == bmb_pkg::ST_CHARGE && state_d == bmb_pkg::ST_FAST) begin
			off_q <= OFW'(OFF_CYC - 1); // R09
		end else if (off_q != '0) begin
			off_q <= off_q - OFW'(1);
		end
	end

	// blanking reloads on input edges and on every entry into charge
	always_ff @(posedge clk) begin
		if (reset) begin
			blank_q <= '0;
		end else if (in_chg) begin
			blank_q <= BLW'(bmb_pkg::BLANK_CYC); // R07
		end else if (state_d == bmb_pkg::ST_CHARGE && state_q != bmb_pkg::ST_CHARGE) begin
			blank_q <= BLW'(bmb_pkg::BLANK_CYC); // R05
		end else if (blank_q != '0) begin
			blank_q <= blank_q - BLW'(1);
		end
	end

	// comparator must stay high for the whole filter span
	always_ff @(posedge clk) begin
		if (reset) begin
			filt_q <= '0;
		end else if (!sense_trip) begin
			filt_q <= '0; // R06
		end else if (filt_q != FLW'(bmb_pkg::FILT_CYC)) begin
			filt_q <= filt_q + FLW'(1); // R06
		end
	end

	////////////////////////////////////////////////////////////////
	// switch drive

	always_comb begin
		case (state_q)
			bmb_pkg::ST_CHARGE: want = dir_q ? bmb_pkg::GT_CHG_REV : bmb_pkg::GT_CHG_FWD; // R12
			bmb_pkg::ST_FAST: want = dir_q ? bmb_pkg::GT_FAST_REV : bmb_pkg::GT_FAST_FWD; // R12
			bmb_pkg::ST_SLOW: want = bmb_pkg::GT_LOW; // R12
			bmb_pkg::ST_BRAKE: want = bmb_pkg::GT_LOW; // R01
			default: want = bmb_pkg::GT_OFF; // R02 R11
		endcase
	end

	// turn-offs act at once; turn-ons wait out the dead time
	always_ff @(posedge clk) begin
		if (reset) begin
			gate_q <= bmb_pkg::GT_OFF;
			dead_q <= '0;
		end else if ((gate_q & ~want) != '0) begin
			gate_q <= bmb_pkg::bmb_gates_type'(gate_q & want); // R13
			dead_q <= DTW'(bmb_pkg::DEAD_CYC - 1); // R13
		end else if (dead_q != '0) begin
			dead_q <= dead_q - DTW'(1); // R13
		end else begin
			gate_q <= want;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	localparam int WAKE_BOUND = bmb_pkg::WAKE_CYC - 1;
	localparam int FILT_D = bmb_pkg::FILT_CYC + 1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_fwd;
		(state_q == bmb_pkg::ST_CHARGE && !dir_q) [*8] |-> gates == bmb_pkg::GT_CHG_FWD;
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward charge pattern wrong"); // R12

	property p_brake;
		(state_q == bmb_pkg::ST_BRAKE) [*8] |-> gates == bmb_pkg::GT_LOW;
	endproperty
	a_brake: assert property (p_brake) else $error("brake not both low"); // R01

	property p_stop;
		state_q == bmb_pkg::ST_OFF |=> gates == bmb_pkg::GT_OFF;
	endproperty
	a_stop: assert property (p_stop) else $error("stop left a switch on"); // R02

	property p_sleep;
		(state_q == bmb_pkg::ST_OFF && in_now == bmb_pkg::IN_STOP && sb_q == SBW'(STANDBY_CYC - 1))
			|=> state_q == bmb_pkg::ST_STANDBY;
	endproperty
	a_sleep: assert property (p_sleep) else $error("standby not entered"); // R02

	property p_restart;
		(state_q == bmb_pkg::ST_OFF && in_now != bmb_pkg::IN_STOP) |=> sb_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("standby timer not restarted"); // R15

	property p_wake;
		(standby && in_now != bmb_pkg::IN_STOP) |=> state_q == bmb_pkg::ST_WAKE ##1 gates == bmb_pkg::GT_OFF;
	endproperty
	a_wake: assert property (p_wake) else $error("standby release wrong"); // R03

	property p_wake_time;
		(standby && in_now != bmb_pkg::IN_STOP)
			|-> ##[1:WAKE_BOUND] (state_q != bmb_pkg::ST_WAKE && !standby);
	endproperty
	a_wake_time: assert property (p_wake_time) else $error("wake took too long"); // R04

	property p_blank_in;
		in_chg |=> blank_q == BLW'(bmb_pkg::BLANK_CYC);
	endproperty
	a_blank_in: assert property (p_blank_in) else $error("input edge did not blank"); // R07

	property p_blank_decay;
		(state_q inside {bmb_pkg::ST_SLOW, bmb_pkg::ST_ZERO}) ##1 state_q == bmb_pkg::ST_CHARGE
			|-> blank_q == BLW'(bmb_pkg::BLANK_CYC);
	endproperty
	a_blank_decay: assert property (p_blank_decay) else $error("decay exit not blanked"); // R05

	property p_filter;
		state_q == bmb_pkg::ST_CHARGE ##1 state_q == bmb_pkg::ST_FAST
			|-> $past(sense_trip, 2) && $past(sense_trip, FILT_D);
	endproperty
	a_filter: assert property (p_filter) else $error("unfiltered trip"); // R06

	property p_off_len;
		state_q == bmb_pkg::ST_CHARGE ##1 state_q == bmb_pkg::ST_FAST |-> off_q == OFW'(OFF_CYC - 1);
	endproperty
	a_off_len: assert property (p_off_len) else $error("off time not fixed"); // R09

	property p_half;
		(state_q == bmb_pkg::ST_FAST && off_q == OFW'(HALF_CYC) && !in_chg && !zero_current)
			|=> state_q == bmb_pkg::ST_SLOW;
	endproperty
	a_half: assert property (p_half) else $error("fast to slow split wrong"); // R10

	property p_zero;
		((state_q == bmb_pkg::ST_FAST || (state_q == bmb_pkg::ST_SLOW && off_q != '0)) && zero_current && !in_chg)
			|=> state_q == bmb_pkg::ST_ZERO ##1 gates == bmb_pkg::GT_OFF;
	endproperty
	a_zero: assert property (p_zero) else $error("zero current not released"); // R11

	property p_resume;
		(state_q inside {bmb_pkg::ST_SLOW, bmb_pkg::ST_ZERO} && off_q == '0 && !in_chg)
			|=> state_q == bmb_pkg::ST_CHARGE;
	endproperty
	a_resume: assert property (p_resume) else $error("charge not resumed"); // R14

	property p_dead;
		$fell(gates.high_switch_a) |-> (!gates.low_switch_a) [*5];
	endproperty
	a_dead: assert property (p_dead) else $error("dead time too short"); // R13

	property p_follow;
		(in_chg && in_now == bmb_pkg::IN_BRAKE && !standby && state_q != bmb_pkg::ST_WAKE)
			|=> state_q == bmb_pkg::ST_BRAKE;
	endproperty
	a_follow: assert property (p_follow) else $error("input change not followed"); // R08

	c_trip: cover property (state_q == bmb_pkg::ST_CHARGE ##1 state_q == bmb_pkg::ST_FAST);
	c_slow: cover property (state_q == bmb_pkg::ST_SLOW ##1 state_q == bmb_pkg::ST_CHARGE);
	c_zero: cover property (state_q == bmb_pkg::ST_ZERO);
	c_wake: cover property (state_q == bmb_pkg::ST_WAKE ##1 state_q == bmb_pkg::ST_CHARGE);

endmodule
`default_nettype wire

/* File: logic/bmb_pkg.sv */
// Function
// R01 - a high b low drives forward, swapped drives reverse, both high brakes low
// R02 - both inputs low turns all switches off; 1 ms later enter standby
// R03 - either direction input high leaves standby for operation
// R04 - outputs stay off after standby release, driven within 30 us
// R05 - comparator ignored for 3.6 us after each decay to charge change
// R06 - comparator must hold 400 ns near threshold before a trip counts
// R07 - every direction input transition restarts the blanking window
// R08 - bridge follows each direction input change for direct pwm
// R09 - off time after a trip has fixed length, independent of current
// R10 - off time is half fast decay then half slow decay
// R11 - zero current during off time turns all switches off till its end
// R12 - charge, fast and slow switch patterns, mirrored for reverse current
// R13 - dead time of 200 to 300 ns on every switch change
// R14 - unblanked trip ends charge; off time end resumes charge in commanded direction
// R15 - standby timer restarts whenever an input goes high
package bmb_pkg;

	localparam int CLK_NS = 40;
	localparam int STANDBY_NS = 1_000_000;
	localparam int STANDBY_CYC = STANDBY_NS / CLK_NS;
	localparam int WAKE_MAX_NS = 30_000;
	localparam int WAKE_CYC = WAKE_MAX_NS / CLK_NS;
	localparam int WAKE_LAT = 3;
	localparam int BLANK_NS = 3_600;
	localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int FILT_NS = 400;
	localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int DEAD_MIN_NS = 200;
	localparam int DEAD_CYC = (DEAD_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int OFF_NS = 25_000;
	localparam int OFF_CYC = OFF_NS / CLK_NS;

	localparam logic [1:0] IN_STOP = 2'h0;
	localparam logic [1:0] IN_REV = 2'h1;
	localparam logic [1:0] IN_FWD = 2'h2;
	localparam logic [1:0] IN_BRAKE = 2'h3;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_STANDBY,
		ST_WAKE,
		ST_BRAKE,
		ST_CHARGE,
		ST_FAST,
		ST_SLOW,
		ST_ZERO
	} bmb_state_type;

	typedef struct packed {
		logic high_switch_a;
		logic high_switch_b;
		logic low_switch_a;
		logic low_switch_b;
	} bmb_gates_type;

	localparam bmb_gates_type GT_OFF = 4'h0;
	localparam bmb_gates_type GT_CHG_FWD = 4'h9;
	localparam bmb_gates_type GT_CHG_REV = 4'h6;
	localparam bmb_gates_type GT_FAST_FWD = 4'h6;
	localparam bmb_gates_type GT_FAST_REV = 4'h9;
	localparam bmb_gates_type GT_LOW = 4'h3;

endpackage

/* File: test/bmb_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bmb_ctrl_model (
	input wire logic clk,
	input wire logic [1:0] cmd,
	output logic dir_in_a,
	output logic dir_in_b
);
	logic [1:0] next_cmd;
	// controller updates its pins just after each edge, holding them a full cycle
	initial begin
		dir_in_a = 1'b0;
		dir_in_b = 1'b0;
		forever begin
			@(posedge clk);
			next_cmd = cmd;
			#2;
			{dir_in_a, dir_in_b} = next_cmd;
		end
	end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int SB_CYC = 50;
	localparam int OFF_CYC = 40;
	typedef struct {
		logic [1:0] cmd;
		bmb_pkg::bmb_gates_type exp;
	} bmb_row_type;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] cmd = bmb_pkg::IN_STOP;
	logic sense_trip = 1'b0;
	logic zero_current = 1'b0;
	wire logic dir_in_a;
	wire logic dir_in_b;
	bmb_pkg::bmb_gates_type gates;
	logic standby;
	int n_fail = 0;
	int n_tests = 0;
	int n6;
	int n3;
	int cyc;
	bmb_row_type rows [6] = '{
		'{bmb_pkg::IN_FWD, bmb_pkg::GT_CHG_FWD},
		'{bmb_pkg::IN_BRAKE, bmb_pkg::GT_LOW},
		'{bmb_pkg::IN_REV, bmb_pkg::GT_CHG_REV},
		'{bmb_pkg::IN_STOP, bmb_pkg::GT_OFF},
		'{bmb_pkg::IN_FWD, bmb_pkg::GT_CHG_FWD},
		'{bmb_pkg::IN_REV, bmb_pkg::GT_CHG_REV}
	};

	always #20 clk = ~clk;

	bmb_bridge_ctrl #(.STANDBY_CYC(SB_CYC), .OFF_CYC(OFF_CYC)) bmb_bridge_ctrl_i (
		.clk(clk),
		.reset(reset),
		.dir_in_a(dir_in_a),
		.dir_in_b(dir_in_b),
		.sense_trip(sense_trip),
		.zero_current(zero_current),
		.gates(gates),
		.standby(standby)
	);

	bmb_ctrl_model bmb_ctrl_model_i (
		.clk(clk),
		.cmd(cmd),
		.dir_in_a(dir_in_a),
		.dir_in_b(dir_in_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk_gates(input string what, input bmb_pkg::bmb_gates_type exp);
		n_tests++;
		if (gates !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, gates);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic seen);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %b seen %b", what, exp, seen);
		end
	endtask

	task automatic chk_int(input string what, input int exp, input int seen);
		n_tests++;
		if (seen != exp) begin
			n_fail++;
			$display("Error %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	task automatic wait_g(input bmb_pkg::bmb_gates_type exp, input int lim, output int n);
		n = 0;
		while (gates !== exp && n < lim) begin
			tick(1);
			n++;
		end
	endtask

	// one trip, then count cycles spent in each decay pattern
	task automatic chop(input int hold, input bmb_pkg::bmb_gates_type fast, input bmb_pkg::bmb_gates_type chg);
		sense_trip = 1'b1;
		n6 = 0;
		n3 = 0;
		for (int i = 0; i < 70; i++) begin
			tick(1);
			if (i == hold - 1) sense_trip = 1'b0;
			if (gates === fast) n6++;
			if (gates === bmb_pkg::GT_LOW) n3++;
		end
		chk_int("fast cycles", OFF_CYC / 2 - bmb_pkg::DEAD_CYC, n6);
		chk_int("slow cycles", OFF_CYC / 2 - bmb_pkg::DEAD_CYC, n3);
		chk_gates("charge after off", chg);
	endtask

	task automatic conclude;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (!reset && ((gates.high_switch_a && gates.low_switch_a) || (gates.high_switch_b && gates.low_switch_b))) begin
			n_fail++;
			$display("Error half bridge overlap expected 0 seen 1");
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end

	initial begin
		tick(10);
		chk_gates("gates in reset", bmb_pkg::GT_OFF);
		chk_bit("standby in reset", 1'b0, standby);
		reset = 1'b0;
		foreach (rows[i]) begin
			cmd = rows[i].cmd;
			tick(12);
			chk_gates("table gates", rows[i].exp);
		end
		cmd = bmb_pkg::IN_FWD;
		tick(120);
		chop(12, bmb_pkg::GT_FAST_FWD, bmb_pkg::GT_CHG_FWD);
		tick(120);
		chop(30, bmb_pkg::GT_FAST_FWD, bmb_pkg::GT_CHG_FWD);
		// trip right after charge resumes is blanked
		sense_trip = 1'b1;
		tick(12);
		sense_trip = 1'b0;
		tick(10);
		chk_gates("blanked trip", bmb_pkg::GT_CHG_FWD);
		tick(120);
		sense_trip = 1'b1;
		tick(8);
		sense_trip = 1'b0;
		tick(10);
		chk_gates("short trip", bmb_pkg::GT_CHG_FWD);
		sense_trip = 1'b1;
		wait_g(bmb_pkg::GT_FAST_FWD, 40, cyc);
		sense_trip = 1'b0;
		zero_current = 1'b1;
		tick(4);
		chk_gates("zero current", bmb_pkg::GT_OFF);
		zero_current = 1'b0;
		tick(10);
		chk_gates("zero rest of off", bmb_pkg::GT_OFF);
		wait_g(bmb_pkg::GT_CHG_FWD, 60, cyc);
		chk_gates("resume charge", bmb_pkg::GT_CHG_FWD);
		cmd = bmb_pkg::IN_STOP;
		tick(40);
		chk_bit("standby early", 1'b0, standby);
		cmd = bmb_pkg::IN_FWD;
		tick(1);
		cmd = bmb_pkg::IN_STOP;
		tick(40);
		chk_bit("standby restart", 1'b0, standby);
		tick(20);
		chk_bit("standby entry", 1'b1, standby);
		chk_gates("standby gates", bmb_pkg::GT_OFF);
		cmd = bmb_pkg::IN_FWD;
		tick(5);
		chk_bit("standby left", 1'b0, standby);
		chk_gates("wake gates", bmb_pkg::GT_OFF);
		wait_g(bmb_pkg::GT_CHG_FWD, 800, cyc);
		chk_gates("after wake", bmb_pkg::GT_CHG_FWD);
		chk_bit("wake in time", 1'b1, cyc + 5 <= bmb_pkg::WAKE_CYC + 1);
		// reverse current chopping
		cmd = bmb_pkg::IN_REV;
		tick(120);
		chop(12, bmb_pkg::GT_FAST_REV, bmb_pkg::GT_CHG_REV);
		// reset in mid run, then stop counts to standby again
		reset = 1'b1;
		cmd = bmb_pkg::IN_STOP;
		tick(4);
		chk_gates("gates in mid reset", bmb_pkg::GT_OFF);
		chk_bit("standby in mid reset", 1'b0, standby);
		reset = 1'b0;
		tick(SB_CYC + 3);
		chk_bit("standby after reset", 1'b1, standby);
		chk_gates("gates after reset", bmb_pkg::GT_OFF);
		conclude();
	end
endmodule
`default_nettype wire
